// ### src/smbob_pkg.sv
// Shared constants for the SMBus block-access output-enable target.
// Assumes one core clock domain and one link (input clock) domain.
package smbob_pkg;
  // Seven-bit target address 1101101
  localparam logic [6:0] SMB_ADDR = 7'h6d;
  localparam logic [7:0] OE_REG_IDX = 8'h00;
  localparam int OUT1_GATE_POS = 5;
  localparam int OUT0_GATE_POS = 3;
  localparam logic [7:0] REG_RESET = 8'hff;
  // Reserved bits of the output-enable register read back as one
  localparam logic [7:0] OE_RSVD_MASK = 8'hd7;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  localparam int REG_COUNT = 8;
  localparam logic [7:0] READ_COUNT = 8'h08;
  localparam int WFIFO_DEPTH = 4;
  localparam int WFIFO_WIDTH = 16;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;

  typedef enum logic [3:0] {
    SMBOB_IDLE, SMBOB_ADDR, SMBOB_INDEX, SMBOB_COUNT, SMBOB_WDATA,
    SMBOB_ACK, SMBOB_TX, SMBOB_TX_ACK, SMBOB_TX_NEXT
  } smbob_state_t;
endpackage : smbob_pkg

// ### src/smbob_fifo.sv
// Synchronous FIFO, valid/ready on both sides.
// Assumes both sides run on the same clock and reset.
module smbob_fifo
  import smbob_pkg::*;
#(
  parameter int WIDTH = WFIFO_WIDTH,
  parameter int DEPTH = WFIFO_DEPTH
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    $error("smbob_fifo depth must be a power of two, at least 2");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic push, pop;

  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
endmodule : smbob_fifo

// ### src/smbob_target.sv
// SMBus target with indexed block write/read and output-enable gating.
// Assumes SCL/SDA are wired-AND outside; the bus engine runs on the input clock.
module smbob_target
  import smbob_pkg::*;
#(
  parameter logic [7:0] BLOCK_READ_COUNT = READ_COUNT
)(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Differential input clock, runs the serial engine
  input wire logic ref_in_clk,
  // Serial bus, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Output enable pins, active low
  input wire logic [1:0] pair_en_n,
  // Gated clock pair enables
  output logic [1:0] clock_pair_out
);
  // Link-domain reset and pin synchronisers
  logic lrst_s1_reg, link_rst_n;
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge ref_in_clk)
  begin
    lrst_s1_reg <= reset_n;
    link_rst_n <= lrst_s1_reg;
    scl_s1_reg <= scl_in;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= sda_in;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
  end

  assign scl_rise = scl_s2_reg && !scl_s3_reg;
  assign scl_fall = !scl_s2_reg && scl_s3_reg;
  assign bus_start = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
  assign bus_stop = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;

  // Serial engine state
  smbob_state_t st_reg, st_next, after_reg, after_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] idx_reg, idx_next;
  logic [7:0] left_reg, left_next;
  logic [7:0] tx_reg, tx_next;
  logic ack_drv_reg, ack_drv_next;
  logic oe_reg, oe_next;
  logic [7:0] rx_byte;
  logic push_valid, push_ready, load_tx;
  logic [7:0] rd_byte;
  logic [7:0] reg_mem [REG_COUNT];

  assign rx_byte = {shift_reg[6:0], sda_s2_reg};

  // Register read view; reserved bits of register 0 forced high
  always_comb
  begin
    if (idx_reg >= 8'(REG_COUNT))
      rd_byte = UNMAPPED_READ;
    else if (idx_reg == OE_REG_IDX)
      rd_byte = reg_mem[0] | OE_RSVD_MASK;
    else
      rd_byte = reg_mem[idx_reg[2:0]];
  end

  always_comb
  begin
    st_next = st_reg;
    after_next = after_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    idx_next = idx_reg;
    left_next = left_reg;
    tx_next = tx_reg;
    ack_drv_next = ack_drv_reg;
    oe_next = oe_reg;
    push_valid = 1'b0;
    load_tx = 1'b0;
    if (bus_start)
    begin
      st_next = SMBOB_ADDR;
      cnt_next = '0;
      oe_next = 1'b0;
      ack_drv_next = 1'b0;
    end
    else if (bus_stop)
    begin
      st_next = SMBOB_IDLE;
      oe_next = 1'b0;
      ack_drv_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        SMBOB_ADDR, SMBOB_INDEX, SMBOB_COUNT, SMBOB_WDATA:
          if (scl_rise)
          begin
            shift_next = rx_byte;
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == BIT_LAST)
            begin
              cnt_next = '0;
              st_next = SMBOB_ACK;
              case (st_reg)
                SMBOB_ADDR:
                  if (shift_reg[6:0] != SMB_ADDR)
                    st_next = SMBOB_IDLE;
                  else if (sda_s2_reg)
                    after_next = SMBOB_TX;
                  else
                    after_next = SMBOB_INDEX;
                SMBOB_INDEX:
                begin
                  idx_next = rx_byte;
                  after_next = SMBOB_COUNT;
                end
                SMBOB_COUNT:
                begin
                  left_next = rx_byte;
                  after_next = SMBOB_WDATA;
                end
                default:
                  // Bytes past the count or with the FIFO full are refused
                  if (left_reg != 8'h00 && push_ready)
                  begin
                    push_valid = 1'b1;
                    idx_next = idx_reg + 8'h01;
                    left_next = left_reg - 8'h01;
                  end
                  else
                    st_next = SMBOB_IDLE;
              endcase
            end
          end
        SMBOB_ACK:
          if (scl_fall)
          begin
            if (!ack_drv_reg)
            begin
              ack_drv_next = 1'b1;
              oe_next = 1'b1;
            end
            else
            begin
              ack_drv_next = 1'b0;
              oe_next = 1'b0;
              st_next = after_reg;
              if (after_reg == SMBOB_TX)
              begin
                // Count byte leads every block read
                tx_next = BLOCK_READ_COUNT;
                oe_next = !BLOCK_READ_COUNT[7];
                cnt_next = '0;
              end
            end
          end
        SMBOB_TX:
          if (scl_rise)
            cnt_next = cnt_reg + 1'b1;
          else if (scl_fall)
          begin
            if (cnt_reg == BIT_DONE)
            begin
              oe_next = 1'b0;
              cnt_next = '0;
              st_next = SMBOB_TX_ACK;
            end
            else
              oe_next = !tx_reg[3'(BIT_LAST - cnt_reg)];
          end
        SMBOB_TX_ACK:
          if (scl_rise)
            // Host not-acknowledge ends the read
            st_next = sda_s2_reg ? SMBOB_IDLE : SMBOB_TX_NEXT;
        SMBOB_TX_NEXT:
          if (scl_fall)
          begin
            load_tx = 1'b1;
            tx_next = rd_byte;
            oe_next = !rd_byte[7];
            idx_next = idx_reg + 8'h01;
            cnt_next = '0;
            st_next = SMBOB_TX;
          end
        default:
          st_next = SMBOB_IDLE;
      endcase
    end
  end

  // Engine advances only on input clock edges, so it is idle without it
  always_ff @(posedge ref_in_clk)
  begin
    if (!link_rst_n)
    begin
      st_reg <= SMBOB_IDLE;
      after_reg <= SMBOB_IDLE;
      cnt_reg <= '0;
      shift_reg <= '0;
      idx_reg <= '0;
      left_reg <= '0;
      tx_reg <= '0;
      ack_drv_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      after_reg <= after_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      idx_reg <= idx_next;
      left_reg <= left_next;
      tx_reg <= tx_next;
      ack_drv_reg <= ack_drv_next;
      oe_reg <= oe_next;
    end
  end

  assign sda_oe = oe_reg;
  assign sda_out = 1'b0;

  // Write path: index and data through the FIFO into the register array
  logic wr_valid, wr_ready;
  logic [WFIFO_WIDTH-1:0] wr_word;

  // Drain stalls while a read byte is fetched, keeping write and read ordered
  assign wr_ready = !load_tx;

  smbob_fifo #(
    .WIDTH(WFIFO_WIDTH),
    .DEPTH(WFIFO_DEPTH)
  ) smbob_fifo_inst (
    .clk(ref_in_clk),
    .rst_n(link_rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({idx_reg, rx_byte}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  always_ff @(posedge ref_in_clk)
  begin
    if (!link_rst_n)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        reg_mem[i] <= REG_RESET;
    end
    else if (wr_valid && wr_ready && wr_word[15:8] < 8'(REG_COUNT))
      reg_mem[wr_word[10:8]] <= wr_word[7:0];
  end

  // Gate bits cross to the core clock as levels
  logic [1:0] gate_link;
  logic [1:0] gate_s1_reg, gate_s2_reg;
  logic [1:0] pin_s1_reg, pin_s2_reg;
  logic [1:0] pair_reg, pair_next;

  assign gate_link = {reg_mem[0][OUT1_GATE_POS], reg_mem[0][OUT0_GATE_POS]};

  for (genvar g = 0; g < 2; g++)
  begin : g_pair
    always_comb
      pair_next[g] = gate_s2_reg[g] && !pin_s2_reg[g];
  end

  always_ff @(posedge core_clk)
  begin
    gate_s1_reg <= gate_link;
    gate_s2_reg <= gate_s1_reg;
    pin_s1_reg <= pair_en_n;
    pin_s2_reg <= pin_s1_reg;
    if (!reset_n)
      pair_reg <= 2'b00;
    else
      pair_reg <= pair_next;
  end

  assign clock_pair_out = pair_reg;

  // Checks, link domain
  sequence s_ack_asserted;
    st_reg == SMBOB_ACK && ack_drv_reg && oe_reg;
  endsequence

  property p_addr_reject;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    (st_reg == SMBOB_ADDR && scl_rise && cnt_reg == BIT_LAST && !bus_start && !bus_stop
      && shift_reg[6:0] != SMB_ADDR) |=> st_reg == SMBOB_IDLE && !oe_reg;
  endproperty
  a_addr_reject: assert property (p_addr_reject) else $error("foreign address taken");

  property p_ack_drive;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    (st_reg == SMBOB_ACK && scl_fall && !ack_drv_reg && !bus_start && !bus_stop)
      |=> s_ack_asserted;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

  property p_ack_hold;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    s_ack_asserted and !scl_fall and !bus_start and !bus_stop |=> oe_reg;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");

  property p_count_first;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    (s_ack_asserted and after_reg == SMBOB_TX && scl_fall && !bus_start && !bus_stop)
      |=> st_reg == SMBOB_TX && tx_reg == BLOCK_READ_COUNT && oe_reg == !tx_reg[7];
  endproperty
  a_count_first: assert property (p_count_first) else $error("count byte missing");

  property p_idx_step;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    push_valid |=> idx_reg == $past(idx_reg) + 8'h01 && st_reg == SMBOB_ACK;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index did not advance");

  property p_write_acked;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    (st_reg == SMBOB_WDATA && scl_rise && cnt_reg == BIT_LAST && !bus_start && !bus_stop
      && left_reg != 8'h00 && push_ready) |-> push_valid ##1 st_reg == SMBOB_ACK;
  endproperty
  a_write_acked: assert property (p_write_acked) else $error("data byte refused");

  property p_rsvd_ones;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    (load_tx && idx_reg == OE_REG_IDX) |=> (tx_reg & OE_RSVD_MASK) == OE_RSVD_MASK;
  endproperty
  a_rsvd_ones: assert property (p_rsvd_ones) else $error("reserved bit read zero");

  property p_nack_ends;
    @(posedge ref_in_clk) disable iff (!link_rst_n)
    (st_reg == SMBOB_TX_ACK && scl_rise && sda_s2_reg && !bus_start && !bus_stop)
      |=> st_reg == SMBOB_IDLE ##1 !oe_reg;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("read kept on after nack");

  // Checks, core domain, then the reset-gate check on the link clock
  property p_gate_wins;
    @(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> (pair_reg & ~$past(gate_s2_reg)) == 2'b00;
  endproperty
  a_gate_wins: assert property (p_gate_wins) else $error("pair on with gate clear");

  property p_reset_gates;
    @(posedge ref_in_clk)
    !link_rst_n |=> reg_mem[0][OUT1_GATE_POS] && reg_mem[0][OUT0_GATE_POS];
  endproperty
  a_reset_gates: assert property (p_reset_gates) else $error("gate bits not one");
endmodule : smbob_target

// ### sim/smbob_host.sv
// Behavioural SMBus host that drives block reads and writes on SCL and SDA.
// Assumes SDA has a pull-up outside; every change lands on a falling clk edge.
module smbob_host
#(
  parameter int QUARTER = 8
)(
  // Timing reference
  input wire logic clk,
  // Serial bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Each SCL phase lasts at least two quarters, well over four link clock periods
  task automatic q_wait(input int n);
    repeat (n * QUARTER) @(negedge clk);
  endtask : q_wait

  // Serves as start and repeated start: SDA falls while SCL is high
  task automatic start_cond();
    sda_low = 1'b0;
    q_wait(1);
    scl = 1'b1;
    q_wait(1);
    sda_low = 1'b1;
    q_wait(1);
    scl = 1'b0;
    q_wait(1);
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    q_wait(1);
    scl = 1'b1;
    q_wait(1);
    sda_low = 1'b0;
    q_wait(2);
  endtask : stop_cond

  task automatic put_bit(input logic b);
    sda_low = ~b;
    q_wait(1);
    scl = 1'b1;
    q_wait(2);
    scl = 1'b0;
    q_wait(1);
  endtask : put_bit

  // SDA is sampled in the middle of the high phase
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    q_wait(1);
    scl = 1'b1;
    q_wait(1);
    b = sda;
    q_wait(1);
    scl = 1'b0;
    q_wait(1);
  endtask : get_bit

  // Index, count and data go out MSB first
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask : send_byte

  // Host acknowledges the byte when ack is set and refuses it otherwise
  task automatic recv_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(~ack);
  endtask : recv_byte
endmodule : smbob_host

// ### sim/smbus_block_access_output_enable_bench.sv
// Self-checking bench: block writes and reads over SMBus, output gating checks.
// Assumes the target and the behavioural host share a pulled-up SDA wire.
module smbus_block_access_output_enable_bench
  import smbob_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ref_in_clk = 1'b0;
  logic ref_run = 1'b1;
  logic scl;
  logic sda;
  logic host_low;
  logic sda_out;
  logic sda_oe;
  logic [1:0] pair_en_n = 2'b00;
  logic [1:0] clock_pair_out;
  logic [7:0] regs [REG_COUNT];
  int n_mismatch = 0;
  int comparisons = 0;

  always #10 core_clk = ~core_clk;

  // Link clock, phase unrelated to the core clock; can be stopped
  initial
  begin
    #7;
    forever
    begin
      #16;
      if (ref_run)
        ref_in_clk = ~ref_in_clk;
    end
  end

  assign sda = ~(host_low | (sda_oe & ~sda_out));

  smbob_target smbob_target_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .ref_in_clk(ref_in_clk),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .pair_en_n(pair_en_n),
    .clock_pair_out(clock_pair_out)
  );

  smbob_host smbob_host_inst (
    .clk(core_clk),
    .sda(sda),
    .scl(scl),
    .sda_low(host_low)
  );

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: acknowledge %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic wr_block(input logic [7:0] n, input logic [7:0] x, input logic [31:0] d);
    logic a;
    smbob_host_inst.start_cond();
    smbob_host_inst.send_byte({SMB_ADDR, 1'b0}, a);
    chk1(a, 1'b1);
    smbob_host_inst.send_byte(n, a);
    chk1(a, 1'b1);
    smbob_host_inst.send_byte(x, a);
    chk1(a, 1'b1);
    for (int i = 0; i < int'(x); i++)
    begin
      smbob_host_inst.send_byte(d[31 - 8 * i -: 8], a);
      chk1(a, 1'b1);
      if (n + i < REG_COUNT)
        regs[n + i] = d[31 - 8 * i -: 8];
    end
    smbob_host_inst.stop_cond();
  endtask : wr_block

  task automatic rd_block(input logic [7:0] n, input int k);
    logic a;
    logic [7:0] got;
    logic [7:0] exp;
    smbob_host_inst.start_cond();
    smbob_host_inst.send_byte({SMB_ADDR, 1'b0}, a);
    chk1(a, 1'b1);
    smbob_host_inst.send_byte(n, a);
    chk1(a, 1'b1);
    smbob_host_inst.start_cond();
    smbob_host_inst.send_byte({SMB_ADDR, 1'b1}, a);
    chk1(a, 1'b1);
    smbob_host_inst.recv_byte(got, 1'b1);
    chk8(got, READ_COUNT);
    for (int i = 0; i < k; i++)
    begin
      smbob_host_inst.recv_byte(got, i < k - 1);
      exp = (n + i < REG_COUNT) ? regs[n + i] : UNMAPPED_READ;
      if (n + i == 0)
        exp = exp | OE_RSVD_MASK;
      chk8(got, exp);
    end
    smbob_host_inst.stop_cond();
  endtask : rd_block

  // Margin over the few core cycles the gate path takes to settle
  task automatic chk_pairs();
    logic [1:0] exp;
    repeat (20) @(negedge core_clk);
    exp[1] = regs[0][OUT1_GATE_POS] & ~pair_en_n[1];
    exp[0] = regs[0][OUT0_GATE_POS] & ~pair_en_n[0];
    chk8({6'h00, clock_pair_out}, {6'h00, exp});
  endtask : chk_pairs

  task automatic t_reset();
    chk_pairs();
    rd_block(8'h00, 1);
  endtask : t_reset

  task automatic t_gates();
    logic [7:0] vals [5] = '{8'h00, 8'h20, 8'h08, 8'h28, 8'hff};
    foreach (vals[i])
    begin
      wr_block(8'h00, 8'h01, {vals[i], 24'h000000});
      chk_pairs();
      rd_block(8'h00, 1);
    end
  endtask : t_gates

  // A cleared gate bit must win over an enabling pin
  task automatic t_pins();
    logic [7:0] vals [2] = '{8'hff, 8'h20};
    foreach (vals[v])
    begin
      wr_block(8'h00, 8'h01, {vals[v], 24'h000000});
      for (int p = 0; p < 4; p++)
      begin
        @(negedge core_clk);
        pair_en_n = 2'(p);
        chk_pairs();
      end
    end
    pair_en_n = 2'b00;
  endtask : t_pins

  // Consecutive registers, then the last two mapped ones running into unmapped space
  task automatic t_block();
    wr_block(8'h01, 8'h03, 32'ha1b2c300);
    rd_block(8'h01, 3);
    wr_block(8'h06, 8'h02, 32'h5aa50000);
    rd_block(8'h06, 3);
  endtask : t_block

  task automatic t_refuse();
    logic a;
    smbob_host_inst.start_cond();
    smbob_host_inst.send_byte({7'h6c, 1'b0}, a);
    chk1(a, 1'b0);
    smbob_host_inst.stop_cond();
    smbob_host_inst.start_cond();
    smbob_host_inst.send_byte({SMB_ADDR, 1'b0}, a);
    smbob_host_inst.send_byte(8'h02, a);
    smbob_host_inst.send_byte(8'h01, a);
    smbob_host_inst.send_byte(8'h3c, a);
    chk1(a, 1'b1);
    regs[2] = 8'h3c;
    smbob_host_inst.send_byte(8'hc3, a);
    chk1(a, 1'b0);
    smbob_host_inst.stop_cond();
    rd_block(8'h02, 2);
  endtask : t_refuse

  // With the input clock stopped the target must stay silent
  task automatic t_noclk();
    logic a;
    ref_run = 1'b0;
    smbob_host_inst.start_cond();
    smbob_host_inst.send_byte({SMB_ADDR, 1'b0}, a);
    chk1(a, 1'b0);
    smbob_host_inst.stop_cond();
    ref_run = 1'b1;
    repeat (20) @(negedge core_clk);
    rd_block(8'h00, 1);
  endtask : t_noclk

  initial
  begin
    foreach (regs[i])
      regs[i] = REG_RESET;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge core_clk);
    t_reset();
    t_gates();
    t_pins();
    t_block();
    t_refuse();
    t_noclk();
    tally_and_finish();
  end

  // Roughly two and a half times the expected run
  initial
  begin
    #1_500_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : smbus_block_access_output_enable_bench
